/* File: verilog/wwd_top.sv */
`timescale 1ns/100ps
`default_nettype none
module wwd_top #(
  parameter int unsigned TIMEOUT_TICKS = wwd_pkg::TIMEOUT_TICKS,
  parameter int unsigned SPACING_TICKS = wwd_pkg::SPACING_TICKS,
  parameter int unsigned HOLD_TICKS    = wwd_pkg::HOLD_TICKS,
  parameter int unsigned RELEASE_TICKS = wwd_pkg::RELEASE_TICKS,
  parameter int unsigned TICK_CYCLES   = wwd_pkg::TICK_CYCLES
) (
  // Clock, reset and clock enable.
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_enable,
  // Monitored party.
  input  wire logic i_trigger_input,
  input  wire logic i_watchdog_enable,
  // Supply comparators.
  input  wire logic i_above_min_level,
  input  wire logic i_above_detect_level,
  input  wire logic i_at_release_level,
  // Load current sensing.
  input  wire logic i_autonomous_mode,
  input  wire logic i_load_at_activation,
  input  wire logic i_load_at_deactivation,
  // Outputs.
  output logic      o_watchdog_fault_out,
  output logic      o_supply_fault_out,
  output logic      o_combined_fault_out,
  output logic      o_low_hysteresis_tap,
  output logic      o_capacitor_discharge,
  output logic      o_monitoring
);
  localparam int W = wwd_pkg::CNT_W;

  //////////////////////////////////////////////////////////////////////////////
  // Time base.

  wwd_tick_if tb ();

  wwd_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_enable (i_enable),
    .tb       (tb)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser and edge detector.

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic trig_pulse;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else if (i_enable)
    begin
      sync1_r <= i_trigger_input;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign trig_pulse = sync2_r & ~sync3_r;

  //////////////////////////////////////////////////////////////////////////////
  // Supply detector with release delay.

  logic          sup_out_r;
  logic          sup_out_nxt;
  logic          charging_r;
  logic          charging_nxt;
  logic [W-1:0]  dly_r;
  logic [W-1:0]  dly_nxt;
  logic          sup_ok;

  always_comb
  begin
    sup_out_nxt  = sup_out_r;
    charging_nxt = charging_r;
    dly_nxt      = dly_r;
    if (!i_above_min_level || !i_above_detect_level)
    begin
      charging_nxt = 1'b0;
      dly_nxt      = '0;
      sup_out_nxt  = 1'b0;
    end
    else if (i_at_release_level && !sup_out_r)
    begin
      charging_nxt = 1'b1;
      if (tb.tick)
      begin
        if (dly_r >= W'(RELEASE_TICKS - 1))
        begin
          sup_out_nxt  = 1'b1;
          charging_nxt = 1'b0;
        end
        else
        begin
          dly_nxt = dly_r + 1'b1;
        end
      end
    end
    else if (!sup_out_r)
    begin
      charging_nxt = 1'b0;
      dly_nxt      = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sup_out_r  <= wwd_pkg::SUPPLY_OUT_RST;
      charging_r <= 1'b0;
      dly_r      <= '0;
    end
    else if (i_enable)
    begin
      sup_out_r  <= sup_out_nxt;
      charging_r <= charging_nxt;
      dly_r      <= dly_nxt;
    end
  end

  assign o_supply_fault_out   = sup_out_r;
  assign o_low_hysteresis_tap = sup_out_r;
  assign o_capacitor_discharge = ~charging_r & ~sup_out_r;
  assign sup_ok = i_above_detect_level & i_above_min_level;

  //////////////////////////////////////////////////////////////////////////////
  // Activation: enable pin and load current hysteresis.

  logic load_act_r;
  logic load_act_nxt;
  logic active;

  always_comb
  begin
    load_act_nxt = load_act_r;
    if (i_load_at_activation)
    begin
      load_act_nxt = 1'b1;
    end
    else if (i_load_at_deactivation)
    begin
      load_act_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      load_act_r <= 1'b0;
    end
    else if (i_enable)
    begin
      load_act_r <= load_act_nxt;
    end
  end

  assign active = i_watchdog_enable & (~i_autonomous_mode | load_act_r);

  //////////////////////////////////////////////////////////////////////////////
  // Window state machine.

  wwd_pkg::wwd_state_type st_r;
  wwd_pkg::wwd_state_type st_nxt;
  logic [W-1:0]           win_r;
  logic [W-1:0]           win_nxt;
  logic [W-1:0]           to_r;
  logic [W-1:0]           to_nxt;
  logic                   wo_r;
  logic                   wo_nxt;

  always_comb
  begin
    st_nxt  = st_r;
    win_nxt = win_r;
    to_nxt  = to_r;
    wo_nxt  = wo_r;
    if (!sup_ok && st_r != wwd_pkg::WWD_ST_FAULT)
    begin
      st_nxt  = wwd_pkg::WWD_ST_INIT;
      win_nxt = '0;
      to_nxt  = '0;
      wo_nxt  = 1'b1;
    end
    else
    begin
      case (st_r)
        wwd_pkg::WWD_ST_INIT:
        begin
          if (sup_out_r)
          begin
            st_nxt = wwd_pkg::WWD_ST_POR;
          end
        end
        wwd_pkg::WWD_ST_POR:
        begin
          if (active)
          begin
            st_nxt  = wwd_pkg::WWD_ST_OPEN;
            win_nxt = '0;
            to_nxt  = '0;
          end
        end
        wwd_pkg::WWD_ST_OPEN, wwd_pkg::WWD_ST_CLOSED:
        begin
          wo_nxt = 1'b1;
          if (!active)
          begin
            st_nxt  = wwd_pkg::WWD_ST_POR;
            win_nxt = '0;
            to_nxt  = '0;
          end
          else if (trig_pulse && st_r == wwd_pkg::WWD_ST_OPEN)
          begin
            st_nxt  = wwd_pkg::WWD_ST_CLOSED;
            win_nxt = '0;
            to_nxt  = '0;
          end
          else if (trig_pulse)
          begin
            st_nxt  = wwd_pkg::WWD_ST_FAULT;
            win_nxt = '0;
            wo_nxt  = 1'b0;
          end
          else if (tb.tick)
          begin
            to_nxt  = to_r + 1'b1;
            win_nxt = win_r + 1'b1;
            if (to_r >= W'(TIMEOUT_TICKS - 1))
            begin
              st_nxt  = wwd_pkg::WWD_ST_FAULT;
              win_nxt = '0;
              wo_nxt  = 1'b0;
            end
            else if (st_r == wwd_pkg::WWD_ST_CLOSED && win_r >= W'(SPACING_TICKS - 1))
            begin
              st_nxt = wwd_pkg::WWD_ST_OPEN;
            end
          end
        end
        wwd_pkg::WWD_ST_FAULT:
        begin
          wo_nxt = 1'b0;
          if (tb.tick)
          begin
            win_nxt = win_r + 1'b1;
            if (win_r >= W'(HOLD_TICKS - 1))
            begin
              st_nxt  = !sup_ok ? wwd_pkg::WWD_ST_INIT
                      : active ? wwd_pkg::WWD_ST_OPEN : wwd_pkg::WWD_ST_POR;
              win_nxt = '0;
              to_nxt  = '0;
              wo_nxt  = 1'b1;
            end
          end
        end
        default:
        begin
          st_nxt = wwd_pkg::WWD_ST_INIT;
          wo_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r  <= wwd_pkg::WWD_ST_INIT;
      win_r <= '0;
      to_r  <= '0;
      wo_r  <= wwd_pkg::FAULT_OUT_RST;
    end
    else if (i_enable)
    begin
      st_r  <= st_nxt;
      win_r <= win_nxt;
      to_r  <= to_nxt;
      wo_r  <= wo_nxt;
    end
  end

  assign tb.run = (st_r == wwd_pkg::WWD_ST_OPEN) || (st_r == wwd_pkg::WWD_ST_CLOSED)
                  || (st_r == wwd_pkg::WWD_ST_FAULT) || charging_r;

  assign o_watchdog_fault_out = wo_r;
  assign o_combined_fault_out = wo_r & sup_out_r;
  assign o_monitoring = (st_r == wwd_pkg::WWD_ST_OPEN) || (st_r == wwd_pkg::WWD_ST_CLOSED);
endmodule
`default_nettype wire

/* File: verilog/wwd_pkg.sv */
package wwd_pkg;
  // Time base tick period and the default intervals, in microseconds.
  localparam int unsigned TICK_US          = 1000;
  localparam int unsigned CLK_NS           = 100;
  localparam int unsigned TICK_CYCLES      = (TICK_US * 1000) / CLK_NS;
  localparam int unsigned TIMEOUT_US       = 40000;
  localparam int unsigned SPACING_US       = 4000;
  localparam int unsigned HOLD_US          = 12000;
  localparam int unsigned RELEASE_US       = 16000;
  localparam int unsigned TIMEOUT_TICKS    = TIMEOUT_US / TICK_US;
  localparam int unsigned SPACING_TICKS    = (SPACING_US + TICK_US - 1) / TICK_US;
  localparam int unsigned HOLD_TICKS       = (HOLD_US + TICK_US - 1) / TICK_US;
  localparam int unsigned RELEASE_TICKS    = (RELEASE_US + TICK_US - 1) / TICK_US;
  localparam int unsigned CNT_W            = 16;
  localparam logic        FAULT_OUT_RST    = 1'b1;
  localparam logic        SUPPLY_OUT_RST   = 1'b0;

  typedef enum logic [2:0]
  {
    WWD_ST_INIT   = 3'h0,
    WWD_ST_POR    = 3'h1,
    WWD_ST_OPEN   = 3'h2,
    WWD_ST_CLOSED = 3'h3,
    WWD_ST_FAULT  = 3'h4
  } wwd_state_type;
endpackage

/* File: verilog/wwd_tick_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface wwd_tick_if;
  logic tick;
  logic run;
  modport gen (input run, output tick);
  modport use_side (output run, input tick);
endinterface
`default_nettype wire

/* File: verilog/wwd_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module wwd_tick_gen #(
  parameter int unsigned TICK_CYCLES = wwd_pkg::TICK_CYCLES
) (
  // Clock, reset and clock enable.
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_enable,
  // Tick carrier.
  wwd_tick_if.gen   tb
);
  logic [23:0] div_r;
  logic [23:0] div_nxt;
  logic        tick_r;
  logic        tick_nxt;

  assign tb.tick = tick_r;

  always_comb
  begin
    div_nxt  = div_r;
    tick_nxt = 1'b0;
    if (!tb.run)
    begin
      div_nxt = 24'h000000;
    end
    else if (div_r == 24'(TICK_CYCLES - 1))
    begin
      div_nxt  = 24'h000000;
      tick_nxt = 1'b1;
    end
    else
    begin
      div_nxt = div_r + 24'h000001;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      div_r  <= 24'h000000;
      tick_r <= 1'b0;
    end
    else if (i_enable)
    begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: verif/wwd_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module wwd_sva #(
  parameter int unsigned HOLD_TICKS  = 3,
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Watched inputs.
  input wire logic i_enable,
  input wire logic i_watchdog_enable,
  input wire logic i_above_detect_level,
  input wire logic i_at_release_level,
  // Watched outputs.
  input wire logic o_watchdog_fault_out,
  input wire logic o_supply_fault_out,
  input wire logic o_combined_fault_out,
  input wire logic o_low_hysteresis_tap,
  input wire logic o_capacitor_discharge,
  input wire logic o_monitoring
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  // Counts the cycles that the watchdog output has stayed low.
  always_comb low_nxt = o_watchdog_fault_out ? 16'h0 : low_r + 16'h1;
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst) low_r <= 16'h0;
    else if (i_enable) low_r <= low_nxt;
  comb_and_a: assert property (o_combined_fault_out == (o_watchdog_fault_out & o_supply_fault_out))
    else $error("combined output is not the AND");
  tap_follow_a: assert property (o_low_hysteresis_tap == o_supply_fault_out)
    else $error("hysteresis tap differs from supply output");
  detect_drop_a: assert property (i_enable && !i_above_detect_level |=>
    !o_supply_fault_out && o_capacitor_discharge) else $error("no reset on detect");
  release_need_a: assert property ($rose(o_supply_fault_out) |-> $past(i_at_release_level))
    else $error("supply released below release level");
  fault_src_a: assert property ($fell(o_watchdog_fault_out) |-> $past(o_monitoring))
    else $error("fault raised outside the windows");
  hold_len_a: assert property ($rose(o_watchdog_fault_out) |-> low_r >= (HOLD_TICKS - 1) *
    TICK_CYCLES && low_r <= HOLD_TICKS * TICK_CYCLES + 2) else $error("fault hold length wrong");
  window_high_a: assert property (o_monitoring |-> o_watchdog_fault_out)
    else $error("watchdog low inside windows");
  disable_stop_a: assert property (i_enable && !i_watchdog_enable |-> ##[1:3] !o_monitoring)
    else $error("monitoring kept while disabled");
  supply_init_a: assert property (i_enable && !i_above_detect_level |-> ##[1:3] !o_monitoring)
    else $error("monitoring kept on supply drop");
endmodule
bind wwd_top wwd_sva #(.HOLD_TICKS(HOLD_TICKS), .TICK_CYCLES(TICK_CYCLES)) u_sva (
  .i_clock, .i_nrst, .i_enable, .i_watchdog_enable, .i_above_detect_level,
  .i_at_release_level, .o_watchdog_fault_out, .o_supply_fault_out, .o_combined_fault_out,
  .o_low_hysteresis_tap, .o_capacitor_discharge, .o_monitoring);
`default_nettype wire

/* File: verif/wwd_mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module wwd_mcu_model (
  // Clock.
  input  wire logic i_clock,
  // Trigger towards the supervisor.
  output var logic  o_trigger_input
);
  initial o_trigger_input = 1'b0;
  task automatic pulse(input int gap, input int high);
    repeat (gap) @(posedge i_clock);
    #1 o_trigger_input = 1'b1;
    repeat (high) @(posedge i_clock);
    #1 o_trigger_input = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/wwd_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  checks++; \
  if ((g) !== (e)) \
  begin \
    n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
  end
module wwd_top_test;
  localparam int TO = 8;
  localparam int SP = 2;
  localparam int HO = 3;
  localparam int RL = 3;
  localparam int TC = 4;
  logic clk, nrst, wde, minl, det, rel;
  logic en = 1'b1;
  logic aut, lact, ldeact;
  logic wd, sup, comb, tap, disc, mon, trig;
  int n_fail = 0;
  int checks = 0;
  int seed = 32'haa83;
  int n, g;
  wwd_top #(.TIMEOUT_TICKS(TO), .SPACING_TICKS(SP), .HOLD_TICKS(HO), .RELEASE_TICKS(RL),
    .TICK_CYCLES(TC)) dut (.i_clock(clk), .i_nrst(nrst), .i_enable(en),
    .i_trigger_input(trig), .i_watchdog_enable(wde), .i_above_min_level(minl),
    .i_above_detect_level(det), .i_at_release_level(rel), .i_autonomous_mode(aut),
    .i_load_at_activation(lact), .i_load_at_deactivation(ldeact),
    .o_watchdog_fault_out(wd), .o_supply_fault_out(sup), .o_combined_fault_out(comb),
    .o_low_hysteresis_tap(tap), .o_capacitor_discharge(disc), .o_monitoring(mon));
  wwd_mcu_model u_mcu (.i_clock(clk), .o_trigger_input(trig));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic sig(input int k);
    sig = (k == 0) ? wd : (k == 1) ? sup : mon;
  endfunction
  function automatic logic in_rng(input int c, input int t);
    in_rng = (c >= (t - 1) * TC) && (c <= t * TC + 3);
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(input int k, input logic v, output int c);
    c = 0;
    while (sig(k) !== v && c < 400)
    begin
      cyc(1);
      c++;
    end
    if (c >= 400)
    begin
      n_fail++;
      $display("[FAIL] wait %0d exp %0h got %0h", k, v, sig(k));
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #(3000 * 100);
    n_fail++;
    final_report();
  end
  initial
  begin
    {nrst, wde, minl, det, rel, aut, lact, ldeact} = 8'h0;
    cyc(20);
    nrst = 1'b1;
    `CHK("comb", 1'b0, comb)
    `CHK("disc", 1'b1, disc)
    wde = 1'b1;
    minl = 1'b1;
    det = 1'b1;
    cyc(10);
    `CHK("sup", 1'b0, sup)
    rel = 1'b1;
    wait_for(1, 1'b1, n);
    `CHK("release", 1'b1, in_rng(n, RL))
    wait_for(2, 1'b1, n);
    `CHK("open", 1'b1, n <= 3)
    `CHK("comb", 1'b1, comb)
    $display("test power_up done");
    repeat (5)
    begin
      g = SP + 2 + $unsigned($random(seed)) % (TO - SP - 3);
      u_mcu.pulse(g * TC, 1 + $unsigned($random(seed)) % 3);
      `CHK("wd", 1'b1, wd)
    end
    en = 1'b0;
    cyc(40);
    en = 1'b1;
    `CHK("freeze", 1'b1, wd)
    `CHK("freeze", 1'b1, mon)
    $display("test windows done");
    u_mcu.pulse((SP + 2) * TC, 1);
    u_mcu.pulse(2, 1);
    wait_for(0, 1'b0, n);
    `CHK("dbl", 1'b1, n <= 4)
    wait_for(0, 1'b1, n);
    `CHK("hold", 1'b1, in_rng(n, HO))
    $display("test double done");
    wait_for(0, 1'b0, n);
    `CHK("tmo", 1'b1, in_rng(n, TO))
    wde = 1'b0;
    wait_for(0, 1'b1, n);
    `CHK("hold", 1'b1, in_rng(n, HO))
    `CHK("mon", 1'b0, mon)
    wde = 1'b1;
    wait_for(2, 1'b1, n);
    cyc((TO - 2) * TC);
    wde = 1'b0;
    cyc(3);
    wde = 1'b1;
    wait_for(2, 1'b1, n);
    wait_for(0, 1'b0, n);
    `CHK("clear", 1'b1, n >= (TO - 1) * TC)
    wait_for(0, 1'b1, n);
    $display("test timeout done");
    {det, rel} = 2'h0;
    cyc(2);
    `CHK("sup", 1'b0, sup)
    `CHK("disc", 1'b1, disc)
    `CHK("mon", 1'b0, mon)
    det = 1'b1;
    cyc(8);
    `CHK("sup", 1'b0, sup)
    rel = 1'b1;
    wait_for(1, 1'b1, n);
    `CHK("release", 1'b1, in_rng(n, RL))
    `CHK("tap", 1'b1, tap)
    `CHK("disc", 1'b0, disc)
    $display("test supply done");
    {aut, lact} = 2'h2;
    cyc(4);
    `CHK("auto", 1'b0, mon)
    lact = 1'b1;
    cyc(1);
    lact = 1'b0;
    cyc(2);
    `CHK("auto", 1'b1, mon)
    ldeact = 1'b1;
    cyc(2);
    `CHK("auto", 1'b0, mon)
    $display("test auto done");
    final_report();
  end
endmodule
`default_nettype wire
